/* hw/mac_regs_pkg.sv */
// constants, register map and types for the buffer address and loopback register block
package mac_regs_pkg;

	// register port pages
	localparam logic [1:0] PAGE_WRITE     = 2'h0;   // write page of split registers
	localparam logic [1:0] PAGE_STATION   = 2'h1;   // station address page
	localparam logic [1:0] PAGE_READ      = 2'h2;   // read page of split registers

	// register port offsets
	localparam logic [4:0] OFS_STATION0   = 5'h11;  // first station address byte
	localparam logic [4:0] OFS_STATION5   = 5'h16;  // last station address byte
	localparam logic [4:0] OFS_RING_START = 5'h11;  // receive ring start page
	localparam logic [4:0] OFS_RING_STOP  = 5'h12;  // receive ring stop page
	localparam logic [4:0] OFS_TX_BASE_RD = 5'h13;  // transmit table base, read
	localparam logic [4:0] OFS_TX_BASE_WR = 5'h15;  // transmit table base, write
	localparam logic [4:0] OFS_TX_LEN_L_RD = 5'h13; // frame length low, read
	localparam logic [4:0] OFS_TX_LEN_L_WR = 5'h15; // frame length low, write
	localparam logic [4:0] OFS_TX_LEN_H   = 5'h16;  // frame length high
	localparam logic [4:0] OFS_RX_DESC_L  = 5'h18;  // receive descriptor pointer low
	localparam logic [4:0] OFS_RX_DESC_H  = 5'h19;  // receive descriptor pointer high
	localparam logic [4:0] OFS_BURST_L    = 5'h1A;  // transmit burst address low
	localparam logic [4:0] OFS_BURST_H    = 5'h1B;  // transmit burst address high
	localparam logic [4:0] OFS_TX_CONFIG  = 5'h1D;  // transmit configuration

	// transmit configuration fields
	localparam int         TXCFG_CRC_INHIBIT_BIT = 0;  // crc generation inhibit
	localparam int         TXCFG_LOOP_LSB        = 1;  // loopback select low bit
	localparam int         TXCFG_LOOP_MSB        = 2;  // loopback select high bit
	localparam logic [7:0] TXCFG_WRITE_MASK      = 8'h07; // bits 7..3 read zero

	// values after reset
	localparam logic [7:0]  TXCFG_RESET  = 8'h00;       // normal mode, crc on
	localparam logic [7:0]  BYTE_RESET   = 8'h00;       // undefined registers start here
	localparam logic [47:0] STATION_RESET = 48'h000000000000;
	localparam logic [7:0]  PAGE_LOW_ZERO = 8'h00;      // implied low address byte

	// loopback selection
	typedef enum logic [1:0] {
		LOOP_NONE     = 2'b00,  // normal operation
		LOOP_PRE_CODEC  = 2'b01,  // internal, ahead of manchester codec
		LOOP_POST_CODEC = 2'b10,  // internal, after codec, pin high
		LOOP_EXTERNAL   = 2'b11   // through transceiver, pin low
	} loopback_mode_t;

endpackage : mac_regs_pkg

/* hw/loopback_decoder.sv */
// decoder from the loopback select field to the loopback path controls
`timescale 1ns/100ps
module loopback_decoder
(
	input  wire logic [1:0] select_in,         // loopback select field
	output logic            pre_codec_out,     // loop ahead of the codec
	output logic            post_codec_out,    // loop after the codec
	output logic            external_out,      // loop through transceiver
	output logic            loop_pin_out       // level for the loopback pin
);

	// one path per nonzero select code, none for 00; only 10 raises the pin
	always_comb
	begin
		pre_codec_out  = 1'b0;
		post_codec_out = 1'b0;
		external_out   = 1'b0;
		loop_pin_out   = 1'b0;
		unique case (mac_regs_pkg::loopback_mode_t'(select_in))
			mac_regs_pkg::LOOP_NONE:
			begin
				pre_codec_out = 1'b0;
			end
			mac_regs_pkg::LOOP_PRE_CODEC:
			begin
				pre_codec_out = 1'b1;
			end
			mac_regs_pkg::LOOP_POST_CODEC:
			begin
				post_codec_out = 1'b1;
				loop_pin_out   = 1'b1;
			end
			mac_regs_pkg::LOOP_EXTERNAL:
			begin
				external_out = 1'b1;
				loop_pin_out = 1'b0;
			end
		endcase
	end

endmodule : loopback_decoder

/* hw/rx_ring_pointer.sv */
// current receive buffer page, advancing round the ring between start and stop pages
`timescale 1ns/100ps
module rx_ring_pointer
(
	input  wire logic       clk_in,           // block clock
	input  wire logic       rst_n_in,         // synchronised reset, active low
	input  wire logic       restart_in,       // pulse: go back to the start page
	input  wire logic       advance_in,       // pulse: receive dma left a page
	input  wire logic [7:0] start_page_in,    // ring start page
	input  wire logic [7:0] stop_page_in,     // first page past the ring
	output logic      [7:0] page_out          // current page, bits 15..8
);

	logic [7:0] page;       // current page register
	logic [7:0] next_page;  // next value of page
	logic [7:0] step_page;  // page plus one

	// restart wins over advance; reaching stop wraps to start
	always_comb
	begin
		step_page = page + 8'h01;
		next_page = page;
		if (restart_in)
		begin
			next_page = start_page_in;
		end
		else if (advance_in)
		begin
			if (step_page == stop_page_in)
			begin
				next_page = start_page_in;
			end
			else
			begin
				next_page = step_page;
			end
		end
	end

	// page register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			page <= mac_regs_pkg::BYTE_RESET;
		end
		else
		begin
			page <= next_page;
		end
	end

	assign page_out = page;

endmodule : rx_ring_pointer

/* hw/mac_buffer_address_and_loopback_regs.sv */
// buffer address, station address and transmit configuration registers with loopback control
`timescale 1ns/100ps
module mac_buffer_address_and_loopback_regs
(
	input  wire logic        mclk_in,               // 40 MHz block clock
	input  wire logic        rstn_in,               // asynchronous reset, active low
	// paged host register port
	input  wire logic        host_map_linked_in,    // 1 selects the linked-list map
	input  wire logic [1:0]  host_page_in,          // register page
	input  wire logic [4:0]  host_offset_in,        // register offset
	input  wire logic        host_read_in,          // read strobe, one cycle
	input  wire logic        host_write_in,         // write strobe, one cycle
	input  wire logic [7:0]  host_wdata_in,         // write data
	output logic      [7:0]  host_rdata_out,        // read data
	output logic             host_rvalid_out,       // read data valid, one cycle
	// dma side
	input  wire logic        rx_ring_restart_in,    // receive dma restarts ring
	input  wire logic        rx_page_advance_in,    // receive dma finished a page
	input  wire logic        tx_burst_load_in,      // dma stores its burst address
	input  wire logic [15:0] tx_burst_value_in,     // burst address from dma
	output logic      [15:0] rx_current_addr_out,   // current receive buffer address
	output logic      [15:0] rx_desc_pointer_out,   // receive descriptor pointer
	output logic      [15:0] tx_table_addr_out,     // transmit table start address
	output logic      [15:0] tx_burst_addr_out,     // transmit burst scratch address
	output logic      [15:0] tx_frame_length_out,   // transmit byte count
	output logic      [47:0] station_address_out,   // individual address
	// transmitter and network side
	output logic             crc_generate_out,      // 1 lets transmitter append crc
	output logic             loop_pre_codec_out,    // internal loop before codec
	output logic             loop_post_codec_out,   // internal loop after codec
	output logic             loop_external_out,     // external loop through transceiver
	output logic             loop_pin_out           // loopback pin to transceiver
);

	// reset synchroniser
	logic       rst_sync1;      // first stage
	logic       rst_n;          // released reset used everywhere

	// software registers
	logic [47:0] station_address_bytes;      // station address, byte 0 low
	logic [7:0]  receive_ring_start_page;    // ring start page
	logic [7:0]  receive_ring_stop_page;     // ring stop page
	logic [7:0]  rx_descriptor_pointer_low;  // descriptor pointer low
	logic [7:0]  rx_descriptor_pointer_high; // descriptor pointer high
	logic [7:0]  tx_burst_address_low;       // burst scratch low
	logic [7:0]  tx_burst_address_high;      // burst scratch high
	logic [7:0]  tx_descriptor_table_base;   // transmit table page
	logic [7:0]  tx_frame_length_low;        // frame length low
	logic [7:0]  tx_frame_length_high;       // frame length high
	logic [7:0]  transmit_configuration;     // transmit configuration

	// next values
	logic [47:0] next_station_address_bytes;
	logic [7:0]  next_receive_ring_start_page;
	logic [7:0]  next_receive_ring_stop_page;
	logic [7:0]  next_rx_descriptor_pointer_low;
	logic [7:0]  next_rx_descriptor_pointer_high;
	logic [7:0]  next_tx_burst_address_low;
	logic [7:0]  next_tx_burst_address_high;
	logic [7:0]  next_tx_descriptor_table_base;
	logic [7:0]  next_tx_frame_length_low;
	logic [7:0]  next_tx_frame_length_high;
	logic [7:0]  next_transmit_configuration;

	// read path and registered outputs
	logic [7:0]  read_mux;          // selected read value
	logic [7:0]  next_rdata;
	logic        next_rvalid;
	logic [7:0]  ring_page;         // current page from ring pointer
	logic        dec_pre, dec_post, dec_ext, dec_pin; // decoded loop paths
	logic [4:0]  station_index;     // offset minus first station offset

	// true when the port names this register in the allowed maps
	function automatic logic port_hit
	(
		input logic       want_normal,
		input logic       want_linked,
		input logic [1:0] want_page,
		input logic [4:0] want_offset,
		input logic       linked,
		input logic [1:0] page,
		input logic [4:0] offset
	);
		logic map_ok;
		map_ok = linked ? want_linked : want_normal;
		return map_ok && (page == want_page) && (offset == want_offset);
	endfunction : port_hit

	// two-stage release of the asynchronous reset
	always_ff @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rst_sync1 <= 1'b0;
			rst_n     <= 1'b0;
		end
		else
		begin
			rst_sync1 <= 1'b1;
			rst_n     <= rst_sync1;
		end
	end

	assign station_index = host_offset_in - mac_regs_pkg::OFS_STATION0;

	// host writes; a dma store of the burst address wins over a host write
	always_comb
	begin
		next_station_address_bytes      = station_address_bytes;
		next_receive_ring_start_page    = receive_ring_start_page;
		next_receive_ring_stop_page     = receive_ring_stop_page;
		next_rx_descriptor_pointer_low  = rx_descriptor_pointer_low;
		next_rx_descriptor_pointer_high = rx_descriptor_pointer_high;
		next_tx_burst_address_low       = tx_burst_address_low;
		next_tx_burst_address_high      = tx_burst_address_high;
		next_tx_descriptor_table_base   = tx_descriptor_table_base;
		next_tx_frame_length_low        = tx_frame_length_low;
		next_tx_frame_length_high       = tx_frame_length_high;
		next_transmit_configuration     = transmit_configuration;
		if (host_write_in)
		begin
			// station bytes: page 1, both maps
			if ((host_page_in == mac_regs_pkg::PAGE_STATION) &&
				(host_offset_in >= mac_regs_pkg::OFS_STATION0) &&
				(host_offset_in <= mac_regs_pkg::OFS_STATION5))
			begin
				next_station_address_bytes[station_index[2:0] * 8 +: 8] = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RING_START,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_receive_ring_start_page = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RING_STOP,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_receive_ring_stop_page = host_wdata_in;
			end
			if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RX_DESC_L,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_rx_descriptor_pointer_low = host_wdata_in;
			end
			if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RX_DESC_H,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_rx_descriptor_pointer_high = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_BURST_L,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_tx_burst_address_low = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_BURST_H,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_tx_burst_address_high = host_wdata_in;
			end
			if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_TX_BASE_WR,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_tx_descriptor_table_base = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_TX_LEN_L_WR,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_tx_frame_length_low = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_TX_LEN_H,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_tx_frame_length_high = host_wdata_in;
			end
			if (port_hit(1'b1, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_TX_CONFIG,
				host_map_linked_in, host_page_in, host_offset_in))
			begin
				next_transmit_configuration = host_wdata_in & mac_regs_pkg::TXCFG_WRITE_MASK;
			end
		end
		// dma keeps its burst start address in the scratch pair
		if (tx_burst_load_in)
		begin
			next_tx_burst_address_low  = tx_burst_value_in[7:0];
			next_tx_burst_address_high = tx_burst_value_in[15:8];
		end
	end

	// register file; configuration clears to normal mode with crc on
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			station_address_bytes      <= mac_regs_pkg::STATION_RESET;
			receive_ring_start_page    <= mac_regs_pkg::BYTE_RESET;
			receive_ring_stop_page     <= mac_regs_pkg::BYTE_RESET;
			rx_descriptor_pointer_low  <= mac_regs_pkg::BYTE_RESET;
			rx_descriptor_pointer_high <= mac_regs_pkg::BYTE_RESET;
			tx_burst_address_low       <= mac_regs_pkg::BYTE_RESET;
			tx_burst_address_high      <= mac_regs_pkg::BYTE_RESET;
			tx_descriptor_table_base   <= mac_regs_pkg::BYTE_RESET;
			tx_frame_length_low        <= mac_regs_pkg::BYTE_RESET;
			tx_frame_length_high       <= mac_regs_pkg::BYTE_RESET;
			transmit_configuration     <= mac_regs_pkg::TXCFG_RESET;
		end
		else
		begin
			station_address_bytes      <= next_station_address_bytes;
			receive_ring_start_page    <= next_receive_ring_start_page;
			receive_ring_stop_page     <= next_receive_ring_stop_page;
			rx_descriptor_pointer_low  <= next_rx_descriptor_pointer_low;
			rx_descriptor_pointer_high <= next_rx_descriptor_pointer_high;
			tx_burst_address_low       <= next_tx_burst_address_low;
			tx_burst_address_high      <= next_tx_burst_address_high;
			tx_descriptor_table_base   <= next_tx_descriptor_table_base;
			tx_frame_length_low        <= next_tx_frame_length_low;
			tx_frame_length_high       <= next_tx_frame_length_high;
			transmit_configuration     <= next_transmit_configuration;
		end
	end

	// read multiplexer; unmapped ports read zero
	always_comb
	begin
		read_mux = 8'h00;
		if ((host_page_in == mac_regs_pkg::PAGE_STATION) &&
			(host_offset_in >= mac_regs_pkg::OFS_STATION0) &&
			(host_offset_in <= mac_regs_pkg::OFS_STATION5))
		begin
			read_mux = station_address_bytes[station_index[2:0] * 8 +: 8];
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_RING_START,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = receive_ring_start_page;
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_RING_STOP,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = receive_ring_stop_page;
		end
		else if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RX_DESC_L,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = rx_descriptor_pointer_low;
		end
		else if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_WRITE, mac_regs_pkg::OFS_RX_DESC_H,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = rx_descriptor_pointer_high;
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_BURST_L,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = tx_burst_address_low;
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_BURST_H,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = tx_burst_address_high;
		end
		else if (port_hit(1'b0, 1'b1, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_TX_BASE_RD,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = tx_descriptor_table_base;
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_TX_LEN_L_RD,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = tx_frame_length_low;
		end
		else if (port_hit(1'b1, 1'b0, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_TX_LEN_H,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = tx_frame_length_high;
		end
		else if (port_hit(1'b1, 1'b1, mac_regs_pkg::PAGE_READ, mac_regs_pkg::OFS_TX_CONFIG,
			host_map_linked_in, host_page_in, host_offset_in))
		begin
			read_mux = transmit_configuration & mac_regs_pkg::TXCFG_WRITE_MASK;
		end
		next_rdata  = host_read_in ? read_mux : 8'h00;
		next_rvalid = host_read_in;
	end

	// current receive page walks the ring
	rx_ring_pointer u_ring
	(
		.clk_in        (mclk_in),
		.rst_n_in      (rst_n),
		.restart_in    (rx_ring_restart_in),
		.advance_in    (rx_page_advance_in),
		.start_page_in (receive_ring_start_page),
		.stop_page_in  (receive_ring_stop_page),
		.page_out      (ring_page)
	);

	// loopback path decode
	loopback_decoder u_loop
	(
		.select_in      (transmit_configuration[mac_regs_pkg::TXCFG_LOOP_MSB:
		                                        mac_regs_pkg::TXCFG_LOOP_LSB]),
		.pre_codec_out  (dec_pre),
		.post_codec_out (dec_post),
		.external_out   (dec_ext),
		.loop_pin_out   (dec_pin)
	);

	// all outputs from flip-flops; page registers carry address bits 15..8
	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_rdata_out      <= 8'h00;
			host_rvalid_out     <= 1'b0;
			rx_current_addr_out <= 16'h0000;
			rx_desc_pointer_out <= 16'h0000;
			tx_table_addr_out   <= 16'h0000;
			tx_burst_addr_out   <= 16'h0000;
			tx_frame_length_out <= 16'h0000;
			station_address_out <= mac_regs_pkg::STATION_RESET;
			crc_generate_out    <= 1'b1;
			loop_pre_codec_out  <= 1'b0;
			loop_post_codec_out <= 1'b0;
			loop_external_out   <= 1'b0;
			loop_pin_out        <= 1'b0;
		end
		else
		begin
			host_rdata_out      <= next_rdata;
			host_rvalid_out     <= next_rvalid;
			rx_current_addr_out <= {ring_page, mac_regs_pkg::PAGE_LOW_ZERO};
			rx_desc_pointer_out <= {rx_descriptor_pointer_high, rx_descriptor_pointer_low};
			tx_table_addr_out   <= {tx_descriptor_table_base, mac_regs_pkg::PAGE_LOW_ZERO};
			tx_burst_addr_out   <= {tx_burst_address_high, tx_burst_address_low};
			tx_frame_length_out <= {tx_frame_length_high, tx_frame_length_low};
			station_address_out <= station_address_bytes;
			crc_generate_out    <= ~transmit_configuration[mac_regs_pkg::TXCFG_CRC_INHIBIT_BIT];
			loop_pre_codec_out  <= dec_pre;
			loop_post_codec_out <= dec_post;
			loop_external_out   <= dec_ext;
			loop_pin_out        <= dec_pin;
		end
	end

endmodule : mac_buffer_address_and_loopback_regs

/* testbench/xcvr_model.sv */
// transceiver stand-in that echoes the wire when the block asks for an external loop
`timescale 1ns/100ps
module xcvr_model
(
	input  wire logic loop_pin_in,   // loopback pin from the block
	input  wire logic external_in,   // block expects the external path
	output logic      echo_out       // transceiver returns what it sends
);
	// pin low keeps the transceiver on the wire, so the far end echoes
	assign echo_out = external_in & ~loop_pin_in;
endmodule : xcvr_model

/* testbench/mac_regs_monitor.sv */
// concurrent checks on the register block ports
`timescale 1ns/100ps
module mac_regs_monitor
(
	input wire logic        mclk_in,
	input wire logic        rstn_in,
	input wire logic        host_map_linked_in,
	input wire logic [1:0]  host_page_in,
	input wire logic [4:0]  host_offset_in,
	input wire logic        host_write_in,
	input wire logic [7:0]  host_wdata_in,
	input wire logic        tx_burst_load_in,
	input wire logic [15:0] tx_burst_value_in,
	input wire logic [15:0] rx_desc_pointer_out,
	input wire logic [15:0] tx_burst_addr_out,
	input wire logic [47:0] station_address_out,
	input wire logic        crc_generate_out,
	input wire logic        loop_pre_codec_out,
	input wire logic        loop_post_codec_out,
	input wire logic        loop_external_out,
	input wire logic        loop_pin_out
);
	// decoded host writes of interest
	wire       wr0 = host_write_in && host_page_in == 2'h0;
	wire       cfg = wr0 && host_offset_in == 5'h1D;
	wire       sta = host_write_in && host_page_in == 2'h1 && host_offset_in == 5'h11;
	wire       dsc = wr0 && host_map_linked_in && host_offset_in == 5'h19;
	wire [1:0] sel = host_wdata_in[2:1];  // loopback select being written
	wire       inh = host_wdata_in[0];    // crc inhibit being written
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	a_pin_post_only: assert property (loop_pin_out == loop_post_codec_out)
		else $error("loop pin level wrong");
	a_loop_onehot: assert property ($onehot0({loop_pre_codec_out, loop_post_codec_out,
		loop_external_out})) else $error("loop paths overlap");
	a_crc_follow: assert property (cfg |-> ##2 crc_generate_out == !$past(inh, 2))
		else $error("crc enable wrong");
	a_pre_decode: assert property (cfg |-> ##2
		loop_pre_codec_out == ($past(sel, 2) == 2'b01)) else $error("pre codec loop wrong");
	a_ext_decode: assert property (cfg |-> ##2
		loop_external_out == ($past(sel, 2) == 2'b11)) else $error("external loop wrong");
	a_station_low: assert property (sta |-> ##2
		station_address_out[7:0] == $past(host_wdata_in, 2)) else $error("station byte wrong");
	a_desc_high: assert property (dsc |-> ##2
		rx_desc_pointer_out[15:8] == $past(host_wdata_in, 2)) else $error("descriptor high wrong");
	a_burst_load: assert property (tx_burst_load_in |-> ##2 tx_burst_addr_out ==
		$past(tx_burst_value_in, 2)) else $error("burst load wrong");
	c_cfg_write: cover property (cfg);
	c_pin_high: cover property (loop_pin_out);
	c_burst: cover property (tx_burst_load_in);
endmodule : mac_regs_monitor

bind mac_buffer_address_and_loopback_regs mac_regs_monitor mon_u (.mclk_in(mclk_in),
	.rstn_in(rstn_in), .host_map_linked_in(host_map_linked_in), .host_page_in(host_page_in),
	.host_offset_in(host_offset_in), .host_write_in(host_write_in),
	.host_wdata_in(host_wdata_in), .tx_burst_load_in(tx_burst_load_in),
	.tx_burst_value_in(tx_burst_value_in), .rx_desc_pointer_out(rx_desc_pointer_out),
	.tx_burst_addr_out(tx_burst_addr_out), .station_address_out(station_address_out),
	.crc_generate_out(crc_generate_out), .loop_pre_codec_out(loop_pre_codec_out),
	.loop_post_codec_out(loop_post_codec_out), .loop_external_out(loop_external_out),
	.loop_pin_out(loop_pin_out));

/* testbench/tb.sv */
// self-checking bench for the buffer address and loopback register block
`timescale 1ns/100ps
module tb;
	logic        mclk_in, rstn_in, map, rd, wr, rvalid, restart, advance, load;
	logic        crc, pre, post, ext, pin, echo;
	logic [1:0]  page, s;
	logic [4:0]  ofs;
	logic [7:0]  wd, rdata;
	logic [7:0]  r [9];   // random register contents
	logic [7:0]  q [$];   // expected read answers, oldest first
	logic [15:0] bval, cur, desc, tbl, burst, len;
	logic [47:0] sta, sa;
	integer      seed = 32'h2a73, fail_count = 0, compares = 0, i;
	// {map, write port, read port} of each plain register
	logic [14:0] ports [9] = '{{1'b0, 7'h11, 7'h51}, {1'b0, 7'h12, 7'h52}, {1'b0, 7'h5A, 7'h5A},
		{1'b0, 7'h5B, 7'h5B}, {1'b0, 7'h15, 7'h53}, {1'b0, 7'h16, 7'h56},
		{1'b1, 7'h18, 7'h18}, {1'b1, 7'h19, 7'h19}, {1'b1, 7'h15, 7'h53}};
	mac_buffer_address_and_loopback_regs dut_u
	(
		.mclk_in(mclk_in), .rstn_in(rstn_in), .host_map_linked_in(map), .host_page_in(page),
		.host_offset_in(ofs), .host_read_in(rd), .host_write_in(wr), .host_wdata_in(wd),
		.host_rdata_out(rdata), .host_rvalid_out(rvalid), .rx_ring_restart_in(restart),
		.rx_page_advance_in(advance), .tx_burst_load_in(load), .tx_burst_value_in(bval),
		.rx_current_addr_out(cur), .rx_desc_pointer_out(desc), .tx_table_addr_out(tbl),
		.tx_burst_addr_out(burst), .tx_frame_length_out(len), .station_address_out(sta),
		.crc_generate_out(crc), .loop_pre_codec_out(pre), .loop_post_codec_out(post),
		.loop_external_out(ext), .loop_pin_out(pin)
	);
	xcvr_model xcvr_u (.loop_pin_in(pin), .external_in(ext), .echo_out(echo));
	// compare and count
	task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// verdict and end of run
	task automatic test_done;
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// one host access; a read notes d as its expected answer
	task automatic acc(input logic w, input logic m, input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		{map, page, ofs, wd, wr, rd} <= {m, a, d, w, ~w};
		if (!w)
			q.push_back(d);
		@(posedge mclk_in);
		{wr, rd} <= 2'b00;
	endtask : acc
	// let registered outputs land
	task automatic settle;
		repeat (2) @(posedge mclk_in);
		#1;
	endtask : settle
	// one-cycle dma pulse {restart, advance, load}
	task automatic strobe(input logic [2:0] p, input logic [15:0] b);
		@(posedge mclk_in);
		{restart, advance, load, bval} <= {p, b};
		@(posedge mclk_in);
		{restart, advance, load} <= 3'b000;
		settle;
	endtask : strobe
	initial
	begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// read answers checked against the oldest note
	always @(negedge mclk_in)
		if (rvalid === 1'b1)
			check("read data", rdata, q.size() ? q.pop_front() : 8'hXX);
	initial
	begin
		{rstn_in, map, page, ofs, rd, wr, wd, restart, advance, load, bval} = '0;
		repeat (16) @(posedge mclk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1;
		check("reset mode", {crc, pre, post, ext, pin}, 5'b10000);
		acc(0, 0, 7'h5D, 8'h00);
		for (i = 0; i < 8; i++)
		begin
			acc(1, i[0], 7'h1D, {5'h1F, i[2:0]});
			settle;
			s = i[2:1];
			check("loop", {crc, pre, post, ext, pin, echo}, {~i[0], s == 1, s == 2, s == 3, s == 2,
				s == 3});
			acc(0, i[1], 7'h5D, {5'h00, i[2:0]});
		end
		for (i = 0; i < 6; i++)
		begin
			sa[8*i +: 8] = $random(seed);
			acc(1, i[0], 7'h31 + i[6:0], sa[8*i +: 8]);
		end
		settle;
		check("station", sta, sa);
		for (i = 0; i < 6; i++)
			acc(0, ~i[0], 7'h31 + i[6:0], sa[8*i +: 8]);
		for (i = 0; i < 9; i++)
			r[i] = $random(seed);
		r[1] = r[0] + 8'h02;
		{r[5], r[4]} = 16'h0040;
		for (i = 0; i < 9; i++)
			acc(1, ports[i][14], ports[i][13:7], r[i]);
		settle;
		check("burst", burst, {r[3], r[2]});
		check("length", len, {r[5], r[4]});
		check("descriptor", desc, {r[7], r[6]});
		check("table", tbl, {r[8], 8'h00});
		acc(1, 1, 7'h11, ~r[0]);
		for (i = 0; i < 9; i++)
			acc(0, ports[i][14], ports[i][6:0], r[i]);
		acc(0, 0, 7'h18, 8'h00);
		acc(0, 1, 7'h7F, 8'h00);
		strobe(3'b100, 16'h0000);
		check("ring start", cur, {r[0], 8'h00});
		strobe(3'b010, 16'h0000);
		check("ring next", cur, {r[0] + 8'h01, 8'h00});
		strobe(3'b010, 16'h0000);
		check("ring wrap", cur, {r[0], 8'h00});
		strobe(3'b001, {r[6], r[7]});
		check("burst load", burst, {r[6], r[7]});
		acc(0, 0, 7'h5A, r[7]);
		for (i = 0; i < 10 && q.size() > 0; i++)
			@(posedge mclk_in);
		check("pending reads", q.size(), 0);
		test_done;
	end
endmodule : tb
